/* core/i2c_register_target.sv */
`timescale 1ns/1ns
// Serial register target: sampled two-wire bus, pointer byte, auto-increment.
module i2c_register_target
  import prox_irq_pkg::*;
#(
  parameter logic [6:0] DEVICE_ADDR = 7'h2A // Bus address; the value is arbitrary.
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic [7:0] readData,
  output logic [7:0] regPointer,
  output reg_write_t writeReq,
  output logic writeValid,
  output logic sdaOut,
  output logic sdaOe
);

  // Two-stage synchronisers; stage 0 is read only by stage 1.
  logic [1:0] sclSync_reg;
  logic [1:0] sdaSync_reg;
  // Delayed copies of the synchronised levels for edge detection.
  logic sclLast_reg;
  logic sdaLast_reg;
  // Byte assembly, bit count, transmit byte and read/write direction.
  logic [7:0] shift_reg;
  logic [3:0] bitCnt_reg;
  logic [7:0] txByte_reg;
  logic readMode_reg;
  bus_state_t state_reg;

  // Decoded bus events.
  wire sclNow = sclSync_reg[1];
  wire sdaNow = sdaSync_reg[1];
  wire sclRise = sclNow & ~sclLast_reg;
  wire sclFall = ~sclNow & sclLast_reg;
  wire startSeen = sclNow & sclLast_reg & sdaLast_reg & ~sdaNow;
  wire stopSeen = sclNow & sclLast_reg & ~sdaLast_reg & sdaNow;
  wire byteDone = (bitCnt_reg == BYTE_BITS);
  wire addrMatch = (shift_reg[7:1] == DEVICE_ADDR);

  // Synchronise the bus pins; the idle bus level is high.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclSync_reg <= 2'h3;
      sdaSync_reg <= 2'h3;
      sclLast_reg <= 1'b1;
      sdaLast_reg <= 1'b1;
    end else begin
      sclSync_reg <= {sclSync_reg[0], sclIn};
      sdaSync_reg <= {sdaSync_reg[0], sdaIn};
      sclLast_reg <= sclNow;
      sdaLast_reg <= sdaNow;
    end
  end

  // Bus sequencer: data is sampled on clock rise and driven after clock fall.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= BUS_IDLE;
      shift_reg <= 8'h00;
      bitCnt_reg <= 4'h0;
      txByte_reg <= 8'h00;
      readMode_reg <= 1'b0;
      regPointer <= 8'h00;
      writeReq <= '0;
      writeValid <= 1'b0;
      sdaOut <= 1'b0;
      sdaOe <= 1'b0;
    end else begin
      writeValid <= 1'b0;
      if (startSeen) begin
        // A start or repeated start always begins a new address byte.
        state_reg <= BUS_ADDR;
        bitCnt_reg <= 4'h0;
        sdaOe <= 1'b0;
      end else if (stopSeen) begin
        // A stop releases the bus whatever the phase.
        state_reg <= BUS_IDLE;
        sdaOe <= 1'b0;
      end else if (sclRise) begin
        shift_reg <= {shift_reg[6:0], sdaNow};
        bitCnt_reg <= bitCnt_reg + 4'h1;
        // The next read byte comes from the following address once the host acknowledges.
        if (state_reg == BUS_READ_ACK && !sdaNow) begin
          regPointer <= regPointer + 8'h01;
        end
      end else if (sclFall) begin
        case (state_reg)
          BUS_ADDR: begin
            if (byteDone && addrMatch) begin
              readMode_reg <= shift_reg[0];
              sdaOe <= 1'b1;
              state_reg <= BUS_ADDR_ACK;
            end else if (byteDone) begin
              state_reg <= BUS_IDLE;
            end
          end
          BUS_ADDR_ACK: begin
            bitCnt_reg <= 4'h0;
            if (readMode_reg) begin
              txByte_reg <= readData;
              sdaOe <= ~readData[7];
              state_reg <= BUS_READ;
            end else begin
              sdaOe <= 1'b0;
              state_reg <= BUS_POINTER;
            end
          end
          BUS_POINTER: begin
            if (byteDone) begin
              regPointer <= shift_reg;
              sdaOe <= 1'b1;
              state_reg <= BUS_POINTER_ACK;
            end
          end
          BUS_POINTER_ACK: begin
            bitCnt_reg <= 4'h0;
            sdaOe <= 1'b0;
            state_reg <= BUS_WRITE;
          end
          BUS_WRITE: begin
            if (byteDone) begin
              writeReq <= '{addr: regPointer, data: shift_reg};
              writeValid <= 1'b1;
              sdaOe <= 1'b1;
              state_reg <= BUS_WRITE_ACK;
            end
          end
          BUS_WRITE_ACK: begin
            bitCnt_reg <= 4'h0;
            regPointer <= regPointer + 8'h01;
            sdaOe <= 1'b0;
            state_reg <= BUS_WRITE;
          end
          BUS_READ: begin
            if (byteDone) begin
              sdaOe <= 1'b0;
              state_reg <= BUS_READ_ACK;
            end else begin
              sdaOe <= ~txByte_reg[6];
              txByte_reg <= {txByte_reg[6:0], 1'b0};
            end
          end
          BUS_READ_ACK: begin
            bitCnt_reg <= 4'h0;
            if (shift_reg[0]) begin
              // A not-acknowledge ends the read.
              state_reg <= BUS_IDLE;
            end else begin
              txByte_reg <= readData;
              sdaOe <= ~readData[7];
              state_reg <= BUS_READ;
            end
          end
          default: begin
            sdaOe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

/* core/prox_irq_pkg.sv */
// Shared register map, field layout and carrier types of the proximity interrupt block.
package prox_irq_pkg;

  // Byte addresses of the registers on the serial register bus.
  localparam logic [7:0] ADDR_RESULT_HI = 8'h87;
  localparam logic [7:0] ADDR_RESULT_LO = 8'h88;
  localparam logic [7:0] ADDR_IRQ_CONTROL = 8'h89;
  localparam logic [7:0] ADDR_LOW_LIMIT_HI = 8'h8A;
  localparam logic [7:0] ADDR_LOW_LIMIT_LO = 8'h8B;
  localparam logic [7:0] ADDR_HIGH_LIMIT_HI = 8'h8C;
  localparam logic [7:0] ADDR_HIGH_LIMIT_LO = 8'h8D;
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h8E;

  // Field positions inside the interrupt control register.
  localparam int CTRL_PERSIST_MSB = 7;
  localparam int CTRL_PERSIST_LSB = 5;
  localparam int CTRL_SAT_BLANK_BIT = 4;
  localparam int CTRL_READY_EN_BIT = 3;
  localparam int CTRL_THR_EN_BIT = 1;
  localparam int CTRL_THR_SEL_BIT = 0;

  // Field positions inside the interrupt status register.
  localparam int FLAG_READY_BIT = 3;
  localparam int FLAG_BELOW_BIT = 1;
  localparam int FLAG_ABOVE_BIT = 0;

  // Writable bit masks; unused bits read as zero.
  localparam logic [7:0] CTRL_WRITE_MASK = 8'hFB;
  localparam logic [7:0] FLAG_MASK = 8'h0B;

  // Reset values and the read value of unmapped bytes.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [15:0] LIMIT_RESET = 16'h0000;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Ambient level code that marks saturation.
  localparam logic [4:0] AMBIENT_MAX = 5'h1F;

  // Bit count of one serial byte.
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // One measurement handed over from the sensor core.
  typedef struct packed {
    logic [15:0] result;
    logic [4:0] ambient;
  } measurement_t;

  // One register write decoded from the serial bus.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_t;

  // Phases of the serial register target.
  typedef enum logic [3:0] {
    BUS_IDLE,
    BUS_ADDR,
    BUS_ADDR_ACK,
    BUS_POINTER,
    BUS_POINTER_ACK,
    BUS_WRITE,
    BUS_WRITE_ACK,
    BUS_READ,
    BUS_READ_ACK
  } bus_state_t;

endpackage

/* core/proximity_threshold_interrupt.sv */
`timescale 1ns/1ns
// Operation
// - Control register holds persistence, blank, enables, select.
// - Saturated ambient code blanks all proximity interrupts.
// - Writable 16-bit low limit, high byte first.
// - Writable 16-bit high limit, high byte first.
// - Status register holds ready, below, above flags.
// - Result above high limit sets above flag.
// - Result below low limit sets below flag.
// - Data-ready interrupt sets the data-ready flag.
// - Flags stay set until host writes one.
// - Pad pulled low while any flag set.
// - Compared value is the readable 16-bit result.
module proximity_threshold_interrupt
  import prox_irq_pkg::*;
#(
  parameter logic [6:0] DEVICE_ADDR = 7'h2A, // Bus address; the value is arbitrary.
  parameter int COUNT_WIDTH = 8 // Width of the persistence counters.
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic coreClk,
  input wire logic coreRst,
  input wire logic [15:0] coreResult,
  input wire logic [4:0] coreAmbient,
  input wire logic coreResultValid,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic intPadOut,
  output logic intPadOe
);

  // Measurement held stable in the core domain until the next one.
  measurement_t coreHold_reg;
  // Event toggle that announces each new held measurement.
  logic coreToggle_reg;
  // Synchroniser of the toggle; stage 0 is read only by stage 1.
  logic [1:0] toggleSync_reg;
  // Last toggle level already taken in the system domain.
  logic toggleSeen_reg;

  // Register contents in the system domain.
  logic [7:0] irqControl_reg;
  logic [15:0] lowLimit_reg;
  logic [15:0] highLimit_reg;
  logic [7:0] irqFlags_reg;
  logic [7:0] irqFlags_next;
  logic [15:0] result_reg;
  logic [4:0] ambient_reg;
  // Consecutive crossing counters.
  logic [COUNT_WIDTH-1:0] aboveCnt_reg;
  logic [COUNT_WIDTH-1:0] aboveCnt_next;
  logic [COUNT_WIDTH-1:0] belowCnt_reg;
  logic [COUNT_WIDTH-1:0] belowCnt_next;

  // Register port of the serial target.
  logic [7:0] regPointer;
  reg_write_t writeReq;
  logic writeValid;
  logic [7:0] readData;

  // Capture each measurement in the core domain and flip the toggle.
  always_ff @(posedge coreClk) begin
    if (coreRst) begin
      coreHold_reg <= '0;
      coreToggle_reg <= 1'b0;
    end else if (coreResultValid) begin
      coreHold_reg <= '{result: coreResult, ambient: coreAmbient};
      coreToggle_reg <= ~coreToggle_reg;
    end
  end

  // Bring the toggle into the system domain through two flip-flops.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      toggleSync_reg <= 2'h0;
      toggleSeen_reg <= 1'b0;
    end else begin
      toggleSync_reg <= {toggleSync_reg[0], coreToggle_reg};
      toggleSeen_reg <= toggleSync_reg[1];
    end
  end

  // A new measurement is present for one cycle after the toggle settles.
  wire newSample = toggleSync_reg[1] ^ toggleSeen_reg;
  // The held word is stable here because it changed on the same core edge as the toggle.
  wire [15:0] sampleResult = coreHold_reg.result;
  wire [4:0] sampleAmbient = coreHold_reg.ambient;

  // Control fields.
  wire [2:0] persistCode = irqControl_reg[CTRL_PERSIST_MSB:CTRL_PERSIST_LSB];
  wire satBlankEn = irqControl_reg[CTRL_SAT_BLANK_BIT];
  wire readyEn = irqControl_reg[CTRL_READY_EN_BIT];
  wire thrEn = irqControl_reg[CTRL_THR_EN_BIT];
  wire thrSel = irqControl_reg[CTRL_THR_SEL_BIT];

  // Blanking looks at the code of the measurement being judged.
  wire [4:0] judgedAmbient = newSample ? sampleAmbient : ambient_reg;
  wire blanked = satBlankEn & (judgedAmbient == AMBIENT_MAX);

  // Strict comparisons against both limits.
  wire isAbove = (sampleResult > highLimit_reg);
  wire isBelow = (sampleResult < lowLimit_reg);

  // Number of consecutive crossings needed, two to the persistence code.
  wire [COUNT_WIDTH-1:0] needCount = COUNT_WIDTH'(1) << persistCode;

  // Thresholds apply to proximity results only with the select at zero.
  wire thrActive = thrEn & ~thrSel & ~blanked;

  // Saturating crossing counters, cleared by any result inside the limit.
  always_comb begin
    aboveCnt_next = aboveCnt_reg;
    belowCnt_next = belowCnt_reg;
    if (newSample) begin
      if (!isAbove) begin
        aboveCnt_next = '0;
      end else if (aboveCnt_reg < needCount) begin
        aboveCnt_next = aboveCnt_reg + COUNT_WIDTH'(1);
      end else begin
        aboveCnt_next = needCount;
      end
      if (!isBelow) begin
        belowCnt_next = '0;
      end else if (belowCnt_reg < needCount) begin
        belowCnt_next = belowCnt_reg + COUNT_WIDTH'(1);
      end else begin
        belowCnt_next = needCount;
      end
    end
  end

  // Events that set the status flags.
  wire aboveEvent = newSample & thrActive & (aboveCnt_next == needCount);
  wire belowEvent = newSample & thrActive & (belowCnt_next == needCount);
  wire readyEvent = newSample & readyEn & ~blanked;

  // Register write decode.
  wire wrControl = writeValid & (writeReq.addr == ADDR_IRQ_CONTROL);
  wire wrLowHi = writeValid & (writeReq.addr == ADDR_LOW_LIMIT_HI);
  wire wrLowLo = writeValid & (writeReq.addr == ADDR_LOW_LIMIT_LO);
  wire wrHighHi = writeValid & (writeReq.addr == ADDR_HIGH_LIMIT_HI);
  wire wrHighLo = writeValid & (writeReq.addr == ADDR_HIGH_LIMIT_LO);
  wire wrFlags = writeValid & (writeReq.addr == ADDR_IRQ_FLAGS);

  // Bits the host clears this cycle and bits hardware sets this cycle.
  wire [7:0] clearMask = wrFlags ? (writeReq.data & FLAG_MASK) : 8'h00;
  wire [7:0] setMask = {4'h0, readyEvent, 1'b0, belowEvent, aboveEvent};

  // Write one clears a flag; a set in the same cycle wins.
  always_comb begin
    irqFlags_next = (irqFlags_reg & ~clearMask) | setMask;
  end

  // Control and limit registers.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqControl_reg <= CTRL_RESET;
      lowLimit_reg <= LIMIT_RESET;
      highLimit_reg <= LIMIT_RESET;
    end else begin
      if (wrControl) irqControl_reg <= writeReq.data & CTRL_WRITE_MASK;
      if (wrLowHi) lowLimit_reg[15:8] <= writeReq.data;
      if (wrLowLo) lowLimit_reg[7:0] <= writeReq.data;
      if (wrHighHi) highLimit_reg[15:8] <= writeReq.data;
      if (wrHighLo) highLimit_reg[7:0] <= writeReq.data;
    end
  end

  // Measurement, counters, flags and the interrupt pad.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      result_reg <= 16'h0000;
      ambient_reg <= 5'h00;
      aboveCnt_reg <= '0;
      belowCnt_reg <= '0;
      irqFlags_reg <= FLAG_RESET;
      intPadOut <= 1'b0;
      intPadOe <= 1'b0;
    end else begin
      if (newSample) begin
        result_reg <= sampleResult;
        ambient_reg <= sampleAmbient;
      end
      aboveCnt_reg <= aboveCnt_next;
      belowCnt_reg <= belowCnt_next;
      irqFlags_reg <= irqFlags_next;
      intPadOut <= 1'b0;
      intPadOe <= |irqFlags_next;
    end
  end

  // Read data for the byte at the bus pointer; unmapped bytes read zero.
  always_comb begin
    case (regPointer)
      ADDR_RESULT_HI: readData = result_reg[15:8];
      ADDR_RESULT_LO: readData = result_reg[7:0];
      ADDR_IRQ_CONTROL: readData = irqControl_reg;
      ADDR_LOW_LIMIT_HI: readData = lowLimit_reg[15:8];
      ADDR_LOW_LIMIT_LO: readData = lowLimit_reg[7:0];
      ADDR_HIGH_LIMIT_HI: readData = highLimit_reg[15:8];
      ADDR_HIGH_LIMIT_LO: readData = highLimit_reg[7:0];
      ADDR_IRQ_FLAGS: readData = irqFlags_reg & FLAG_MASK;
      default: readData = READ_UNMAPPED;
    endcase
  end

  // Serial register target.
  i2c_register_target #(
    .DEVICE_ADDR(DEVICE_ADDR)
  ) busTarget (
    .clk(clk),
    .sys_rst(sys_rst),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .readData(readData),
    .regPointer(regPointer),
    .writeReq(writeReq),
    .writeValid(writeValid),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe)
  );

  // Checks in the system clock domain.
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // A permitted data-ready event shows in the flag on the next cycle.
  ready_flag_set_a: assert property (readyEvent |=> irqFlags_reg[FLAG_READY_BIT])
    else $error("ready flag not set after new sample");

  // Without its enable no new data-ready flag appears.
  ready_gate_a: assert property (newSample && !readyEn && !irqFlags_reg[FLAG_READY_BIT]
    |=> !irqFlags_reg[FLAG_READY_BIT])
    else $error("ready flag set while disabled");

  // While blanked, a clear flag register stays clear.
  sat_blank_a: assert property (blanked && newSample && irqFlags_reg == 8'h00
    |=> irqFlags_reg == 8'h00)
    else $error("flag set during saturation blanking");

  // A strict upper crossing with persistence one sets the above flag.
  above_set_a: assert property (newSample && thrEn && !thrSel && !blanked
    && persistCode == 3'h0 && sampleResult > highLimit_reg |=> irqFlags_reg[FLAG_ABOVE_BIT])
    else $error("above flag missing after upper crossing");

  // A strict lower crossing with persistence one sets the below flag.
  below_set_a: assert property (newSample && thrEn && !thrSel && !blanked
    && persistCode == 3'h0 && sampleResult < lowLimit_reg |=> irqFlags_reg[FLAG_BELOW_BIT])
    else $error("below flag missing after lower crossing");

  // With thresholds disabled, clear crossing flags stay clear.
  thr_gate_a: assert property (!thrEn && !irqFlags_reg[FLAG_ABOVE_BIT]
    && !irqFlags_reg[FLAG_BELOW_BIT] |=> !irqFlags_reg[FLAG_ABOVE_BIT]
    && !irqFlags_reg[FLAG_BELOW_BIT])
    else $error("threshold flag set while disabled");

  // A set above flag survives every cycle without a clearing write.
  flag_sticky_a: assert property (irqFlags_reg[FLAG_ABOVE_BIT]
    && !clearMask[FLAG_ABOVE_BIT] |=> irqFlags_reg[FLAG_ABOVE_BIT])
    else $error("above flag dropped without clear");

  // A set below flag survives every cycle without a clearing write.
  below_sticky_a: assert property (irqFlags_reg[FLAG_BELOW_BIT]
    && !clearMask[FLAG_BELOW_BIT] |=> irqFlags_reg[FLAG_BELOW_BIT])
    else $error("below flag dropped without clear");

  // Writing one clears the ready flag when no ready event sets it again.
  flag_clear_a: assert property (clearMask[FLAG_READY_BIT] && !readyEvent
    |=> !irqFlags_reg[FLAG_READY_BIT])
    else $error("ready flag not cleared by write");

  // The pad is driven low exactly while any flag is set.
  pad_follows_a: assert property (##1 intPadOe == (irqFlags_reg != 8'h00))
    else $error("interrupt pad disagrees with flags");

  // A new sample never takes a counter past the persistence target.
  // A lowered target is only applied at the next sample, so the held count may exceed it.
  persist_bound_a: assert property (newSample |-> aboveCnt_next <= needCount
    && belowCnt_next <= needCount)
    else $error("crossing counter above persistence target");

  // Short of the persistence target an upper crossing raises no flag.
  persist_wait_a: assert property (newSample && isAbove
    && aboveCnt_reg + COUNT_WIDTH'(1) < needCount && !irqFlags_reg[FLAG_ABOVE_BIT]
    |=> !irqFlags_reg[FLAG_ABOVE_BIT])
    else $error("above flag before persistence target");

  // With the source select set, clear crossing flags stay clear.
  sel_gate_a: assert property (thrSel && !irqFlags_reg[FLAG_ABOVE_BIT]
    && !irqFlags_reg[FLAG_BELOW_BIT] |=> !irqFlags_reg[FLAG_ABOVE_BIT]
    && !irqFlags_reg[FLAG_BELOW_BIT])
    else $error("threshold flag set with source select");

  // A control write lands with its unused bit forced to zero.
  ctrl_write_a: assert property (wrControl
    |=> irqControl_reg == ($past(writeReq.data) & CTRL_WRITE_MASK))
    else $error("control write not applied");

  // Main scenarios.
  ready_seen_c: cover property (readyEvent ##1 intPadOe);
  above_seen_c: cover property (aboveEvent && persistCode != 3'h0);
  clear_seen_c: cover property (irqFlags_reg != 8'h00 ##1 clearMask != 8'h00 ##1 !intPadOe);
  blank_seen_c: cover property (newSample && blanked && thrEn);

endmodule

/* tb/i2c_host_model.sv */
`timescale 1ns/1ns
// Host on the two-wire register bus; pins move just after a falling clock edge.
module i2c_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2A // Bus address; the value is arbitrary.
) (
  input wire logic clk,
  input wire logic sdaWire,
  output logic scl,
  output logic sdaLow
);
  logic ackFail; // Set when an expected acknowledge is missing.
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
    ackFail = 1'b0;
  end
  // One third of a bit; leaves over four cycles of setup and hold.
  task automatic half();
    repeat (6) @(negedge clk);
  endtask
  // A one releases the line to the pull-up.
  task automatic bitOut(input logic b);
    sdaLow = !b;
    half();
    scl = 1'b1;
    half();
    scl = 1'b0;
    half();
  endtask
  // The line is released and sampled in the middle of the high phase.
  task automatic bitIn(output logic b);
    sdaLow = 1'b0;
    half();
    scl = 1'b1;
    repeat (3) @(negedge clk);
    b = sdaWire;
    repeat (3) @(negedge clk);
    scl = 1'b0;
    half();
  endtask
  // Start, also usable as a repeated start.
  task automatic start();
    sdaLow = 1'b0;
    half();
    scl = 1'b1;
    half();
    sdaLow = 1'b1;
    half();
    scl = 1'b0;
    half();
  endtask
  // Stop leaves both lines high.
  task automatic stop();
    sdaLow = 1'b1;
    half();
    scl = 1'b1;
    half();
    sdaLow = 1'b0;
    half();
  endtask
  // Sends a byte most significant bit first and takes the acknowledge.
  task automatic byteOut(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) bitOut(d[i]);
    bitIn(a);
    if (a) ackFail = 1'b1;
  endtask
  // Pointer byte then one data byte.
  task automatic writeReg(input logic [7:0] addr, input logic [7:0] d);
    start();
    byteOut({DEV_ADDR, 1'b0});
    byteOut(addr);
    byteOut(d);
    stop();
  endtask
  // Pointer byte, repeated start, one byte read and ended by a not-acknowledge.
  task automatic readReg(input logic [7:0] addr, output logic [7:0] d);
    logic b;
    start();
    byteOut({DEV_ADDR, 1'b0});
    byteOut(addr);
    start();
    byteOut({DEV_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) begin
      bitIn(b);
      d[i] = b;
    end
    bitOut(1'b1);
    stop();
  endtask
endmodule

/* tb/tb_proximity_threshold_interrupt.sv */
`timescale 1ns/1ns
module tb_proximity_threshold_interrupt;
  import prox_irq_pkg::*;
  localparam logic [6:0] BUS_ADDR = 7'h2A; // Bus address; the value is arbitrary.
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic coreClk = 1'b0;
  logic coreRst = 1'b1;
  logic [15:0] coreResult = 16'h0000;
  logic [4:0] coreAmbient = 5'h00;
  logic coreResultValid = 1'b0;
  logic scl, sdaLow, sdaOut, sdaOe, intPadOut, intPadOe;
  logic sdaWire; // Pulled-up data line seen by both parties.
  logic intPad; // Pulled-up interrupt pad.
  int nMismatch = 0;
  int samplesChecked = 0;
  logic [15:0] thrVal [4] = '{16'h0200, 16'h0201, 16'h0100, 16'h00FF};
  logic [7:0] thrFlag [4] = '{8'h00, 8'h01, 8'h00, 8'h02};
  assign sdaWire = !((sdaOe && !sdaOut) || sdaLow);
  assign intPad = !(intPadOe && !intPadOut);
  // System clock, and a core clock of unrelated phase.
  always #2 clk = ~clk;
  initial begin
    #7;
    forever #32 coreClk = ~coreClk;
  end
  proximity_threshold_interrupt #(.DEVICE_ADDR(BUS_ADDR)) i_dut (.clk(clk), .sys_rst(sysRst),
    .coreClk(coreClk), .coreRst(coreRst), .coreResult(coreResult), .coreAmbient(coreAmbient),
    .coreResultValid(coreResultValid), .sclIn(scl), .sdaIn(sdaWire), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .intPadOut(intPadOut), .intPadOe(intPadOe));
  i2c_host_model #(.DEV_ADDR(BUS_ADDR)) i_host (.clk(clk), .sdaWire(sdaWire), .scl(scl),
    .sdaLow(sdaLow));
  // Compares one byte.
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Compares one pin level.
  task automatic cmp1(input logic got, input logic exp);
    samplesChecked++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Reads a register over the bus and compares it.
  task automatic checkReg(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_host.readReg(a, d);
    cmp8(d, exp);
  endtask
  // Both limits, high byte first.
  task automatic setLimits(input logic [15:0] lo, input logic [15:0] hi);
    i_host.writeReg(ADDR_LOW_LIMIT_HI, lo[15:8]);
    i_host.writeReg(ADDR_LOW_LIMIT_LO, lo[7:0]);
    i_host.writeReg(ADDR_HIGH_LIMIT_HI, hi[15:8]);
    i_host.writeReg(ADDR_HIGH_LIMIT_LO, hi[7:0]);
  endtask
  // One measurement; the data lines are scrambled once the valid pulse is gone.
  task automatic measure(input logic [15:0] r, input logic [4:0] amb);
    @(negedge coreClk);
    coreResult = r;
    coreAmbient = amb;
    coreResultValid = 1'b1;
    @(negedge coreClk);
    coreResultValid = 1'b0;
    coreResult = ~r;
    coreAmbient = ~amb;
    repeat (3) @(negedge coreClk);
    @(negedge clk);
  endtask
  task automatic endTest(input string s);
    $display("test %s finished", s);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // A hung run counts as a mismatch.
  initial begin
    repeat (100000) @(posedge clk);
    nMismatch++;
    summarize();
  end
  // Main sequence.
  initial begin
    repeat (2) @(negedge coreClk);
    coreRst = 1'b0;
    @(negedge clk);
    sysRst = 1'b0;
    repeat (8) @(negedge clk);
    cmp1(intPad, 1'b1);
    for (int a = 'h87; a <= 'h8E; a++) checkReg(8'(a), 8'h00);
    checkReg(8'h90, READ_UNMAPPED);
    endTest("reset");
    i_host.writeReg(ADDR_IRQ_CONTROL, 8'hFF);
    checkReg(ADDR_IRQ_CONTROL, 8'hFB);
    for (int i = 0; i < 4; i++) i_host.writeReg(ADDR_LOW_LIMIT_HI + 8'(i), 8'h12 + 8'(34 * i));
    for (int i = 0; i < 4; i++) begin
      checkReg(ADDR_LOW_LIMIT_HI + 8'(i), 8'h12 + 8'(34 * i));
    end
    i_host.writeReg(ADDR_RESULT_HI, 8'hAA);
    checkReg(ADDR_RESULT_HI, 8'h00);
    i_host.writeReg(ADDR_IRQ_FLAGS, 8'hFF);
    checkReg(ADDR_IRQ_FLAGS, 8'h00);
    endTest("registers");
    i_host.writeReg(ADDR_IRQ_CONTROL, 8'h08);
    setLimits(16'h0000, 16'hFFFF);
    measure(16'h1234, 5'h00);
    cmp1(intPad, 1'b0);
    checkReg(ADDR_IRQ_FLAGS, 8'h08);
    checkReg(ADDR_RESULT_HI, 8'h12);
    checkReg(ADDR_RESULT_LO, 8'h34);
    i_host.writeReg(ADDR_IRQ_FLAGS, 8'h00);
    checkReg(ADDR_IRQ_FLAGS, 8'h08);
    i_host.writeReg(ADDR_IRQ_FLAGS, 8'h08);
    checkReg(ADDR_IRQ_FLAGS, 8'h00);
    cmp1(intPad, 1'b1);
    i_host.writeReg(ADDR_IRQ_CONTROL, 8'h00);
    measure(16'h0042, 5'h00);
    checkReg(ADDR_IRQ_FLAGS, 8'h00);
    endTest("ready");
    i_host.writeReg(ADDR_IRQ_CONTROL, 8'h02);
    setLimits(16'h0100, 16'h0200);
    for (int i = 0; i < 4; i++) begin
      measure(thrVal[i], 5'h00);
      checkReg(ADDR_IRQ_FLAGS, thrFlag[i]);
      i_host.writeReg(ADDR_IRQ_FLAGS, 8'h03);
    end
    i_host.writeReg(ADDR_IRQ_CONTROL, 8'h00);
    measure(16'h0300, 5'h00);
    checkReg(ADDR_IRQ_FLAGS, 8'h00);
    // With the source select set, an upper crossing must not raise a flag.
    i_host.writeReg(ADDR_IRQ_CONTROL, 8'h03);
    measure(16'h0300, 5'h00);
    checkReg(ADDR_IRQ_FLAGS, 8'h00);
    endTest("thresholds");
    i_host.writeReg(ADDR_IRQ_CONTROL, 8'h42);
    for (int k = 0; k < 2; k++) begin
      measure(16'h0150, 5'h00);
      for (int i = 0; i < 3; i++) measure(16'h0300, 5'h00);
      checkReg(ADDR_IRQ_FLAGS, 8'h00);
    end
    measure(16'h0300, 5'h00);
    checkReg(ADDR_IRQ_FLAGS, 8'h01);
    i_host.writeReg(ADDR_IRQ_FLAGS, 8'h0B);
    endTest("persistence");
    i_host.writeReg(ADDR_IRQ_CONTROL, 8'h1A);
    measure(16'h0300, 5'h1F);
    checkReg(ADDR_IRQ_FLAGS, 8'h00);
    measure(16'h0300, 5'h1E);
    checkReg(ADDR_IRQ_FLAGS, 8'h09);
    cmp1(i_host.ackFail, 1'b0);
    endTest("blanking");
    summarize();
  end
endmodule
